/* File: src/wakeup_clk.sv */
// Purpose: Wake-up handling and baud clock generation of the serial control port.
// Assumes: clk_i stands in for the crystal clock; port pins are synchronised here.
// Notes: Clock outputs toggle on divider enables, never on a second clock.
// Overview of operation
// - Enable rising while asleep starts the oscillator, settling up to 1.5 ms.
// - That same edge fixes the serial clock sampling edge.
// - That edge decides host clock activation from setting and data line level.
// - Crystal-dependent functions stay unavailable until the oscillator settles.
// - Generate a host clock and a 50% duty baud clock.
// - Host clock stays aligned to data clock, realigned on reprogram or transmit start.
// - Three data paths: asynchronous, synchronous, Manchester; command selects one.
// - Enable low beyond 2^16 crystal cycles enters sleep.
// - Serial clock low at wake means sample on falling edges, else rising.
// - Host clock modes off, always, or transmit-only; kept across sleep.
`timescale 1ns/10ps
`include "wakeup_clk_params.svh"
module wakeup_clk #(
  parameter int SETTLE_CYCLES = `XTAL_SETTLE_CYCLES,
  parameter int SLEEP_CYCLES = `SLEEP_TIMEOUT_CYCLES,
  parameter int DIV_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic port_enable_i,
  input wire logic port_clk_i,
  input wire logic serial_data_line_i,
  input wire logic [1:0] host_clk_mode_i,
  input wire logic [1:0] data_mode_i,
  input wire logic [DIV_WIDTH-1:0] baud_div_i,
  input wire logic clk_cfg_load_i,
  input wire logic tx_start_i,
  input wire logic tx_active_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic tx_bit_i,
  output logic sleep_state_o,
  output logic osc_run_o,
  output logic osc_stable_o,
  output logic sample_on_rise_o,
  output logic host_clock_out_o,
  output logic baud_clk_o,
  output logic data_out_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] en_sync;
  logic [1:0] pclk_sync;
  logic [1:0] dat_sync;
  logic en_prev;
  logic en_rise;

  // Only the second stage is read, so a first stage caught between levels never
  // reaches the edge detector or the wake-up latches.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_sync <= 2'h0;
      pclk_sync <= 2'h0;
      dat_sync <= 2'h0;
      en_prev <= 1'b0;
    end else begin
      en_sync <= {en_sync[0], port_enable_i};
      pclk_sync <= {pclk_sync[0], port_clk_i};
      dat_sync <= {dat_sync[0], serial_data_line_i};
      en_prev <= en_sync[1];
    end
  end

  assign en_rise = en_sync[1] && !en_prev;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // The unused data mode code counts as asynchronous, so the FIFO is never
  // drained into an output that does not show the bits.
  function automatic logic clocked_mode(input logic [1:0] mode);
    return (mode == `MODE_SYNC) || (mode == `MODE_MANCH);
  endfunction : clocked_mode

  function automatic logic host_clk_allowed(input logic [1:0] mode, input logic active);
    return (mode == `HOST_CLK_ALWAYS) || ((mode == `HOST_CLK_TX) && active);
  endfunction : host_clk_allowed

  // ----------------------------------------------------------------
  // Wake-up state machine
  // ----------------------------------------------------------------
  wakeup_clk_pkg::wake_state_type state;
  wakeup_clk_pkg::wake_state_type next_state;
  wakeup_clk_pkg::wake_latch_type latch;
  wakeup_clk_pkg::wake_latch_type next_latch;
  logic [31:0] settle_cnt;
  logic [31:0] next_settle_cnt;
  logic [31:0] low_cnt;
  logic [31:0] next_low_cnt;
  logic [1:0] mode_kept;
  logic [1:0] next_mode_kept;

  // The settle count runs on the system clock, which stands in for the crystal;
  // its default covers the longest start-up of the oscillator.
  always_comb begin
    next_state = state;
    next_latch = latch;
    next_settle_cnt = settle_cnt;
    next_mode_kept = mode_kept;
    next_low_cnt = en_sync[1] ? 32'h0 : low_cnt + 32'h1;
    if (clk_cfg_load_i) begin
      next_mode_kept = host_clk_mode_i;
    end
    case (state)
      wakeup_clk_pkg::st_sleep: begin
        next_low_cnt = 32'h0;
        if (en_rise) begin
          next_state = wakeup_clk_pkg::st_settle;
          next_settle_cnt = 32'h0;
          next_latch.sample_on_rise = pclk_sync[1];
          next_latch.host_clk_on = (mode_kept != `HOST_CLK_OFF) && dat_sync[1];
        end
      end
      wakeup_clk_pkg::st_settle: begin
        next_settle_cnt = settle_cnt + 32'h1;
        if (settle_cnt >= SETTLE_CYCLES - 1) begin
          next_state = wakeup_clk_pkg::st_ready;
        end
      end
      default: begin
        next_state = wakeup_clk_pkg::st_ready;
      end
    endcase
    if (state != wakeup_clk_pkg::st_sleep && low_cnt >= SLEEP_CYCLES) begin
      next_state = wakeup_clk_pkg::st_sleep;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= wakeup_clk_pkg::st_sleep;
      latch <= '0;
      settle_cnt <= 32'h0;
      low_cnt <= 32'h0;
      mode_kept <= `HOST_CLK_OFF;
    end else begin
      state <= next_state;
      latch <= next_latch;
      settle_cnt <= next_settle_cnt;
      low_cnt <= next_low_cnt;
      mode_kept <= next_mode_kept;
    end
  end

  logic stable;
  assign stable = state == wakeup_clk_pkg::st_ready;

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  // Restarting the divider on reprogramming or transmit start keeps both
  // clocks phase-locked to the data clock, at the cost of one short period.
  logic [DIV_WIDTH-1:0] div_cnt;
  logic [DIV_WIDTH-1:0] next_div_cnt;
  logic baud;
  logic next_baud;
  logic hclk;
  logic next_hclk;
  logic realign;
  logic half_tick;

  assign realign = clk_cfg_load_i || tx_start_i;
  assign half_tick = stable && !realign && (div_cnt == baud_div_i);

  always_comb begin
    next_div_cnt = div_cnt + 1'b1;
    next_baud = baud;
    next_hclk = hclk;
    if (!stable || realign) begin
      next_div_cnt = '0;
      next_baud = 1'b0;
      next_hclk = 1'b0;
    end else if (half_tick) begin
      next_div_cnt = '0;
      next_baud = !baud;
      next_hclk = !hclk;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= '0;
      baud <= 1'b0;
      hclk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      baud <= next_baud;
      hclk <= next_hclk;
    end
  end

  // ----------------------------------------------------------------
  // Transmit data paths
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_bit;
  logic bit_take;
  logic baud_fall;
  logic baud_rise;
  logic cur_bit;
  logic next_cur_bit;
  logic dout;
  logic next_dout;

  assign baud_rise = half_tick && !baud;
  assign baud_fall = half_tick && baud;
  // baud clock rising edges drain the FIFO in the clocked modes; the FIFO absorbs jitter.
  assign bit_take = clocked_mode(data_mode_i) && baud_rise;

  wakeup_clk_fifo #(
    .WIDTH(1),
    .DEPTH(`TX_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(tx_valid_i && stable),
    .in_ready_o(fifo_ready),
    .in_data_i(tx_bit_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(bit_take),
    .out_data_o(fifo_bit)
  );

  // Ready stays low until the crystal is usable, so the host cannot queue bits
  // that would be clocked out on an unsettled baud clock.
  assign tx_ready_o = fifo_ready && stable;

  always_comb begin
    next_cur_bit = cur_bit;
    next_dout = dout;
    if (bit_take && fifo_valid) begin
      next_cur_bit = fifo_bit;
    end
    case (data_mode_i)
      `MODE_SYNC: begin
        if (bit_take && fifo_valid) begin
          next_dout = fifo_bit;
        end
      end
      `MODE_MANCH: begin
        if (bit_take && fifo_valid) begin
          next_dout = !fifo_bit;
        end else if (baud_fall) begin
          next_dout = cur_bit;
        end
      end
      default: begin
        next_dout = dat_sync[1];
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_bit <= 1'b0;
      dout <= 1'b0;
    end else begin
      cur_bit <= next_cur_bit;
      dout <= next_dout;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic hclk_en;
  logic hclk_out;
  logic next_hclk_out;

  assign hclk_en = latch.host_clk_on && host_clk_allowed(mode_kept, tx_active_i);

  // The gate acts on the next level and is registered, so a change of the
  // transmit flag takes effect at the next system clock edge and can cut a host clock level short.
  always_comb begin
    next_hclk_out = next_hclk && hclk_en;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hclk_out <= 1'b0;
    end else begin
      hclk_out <= next_hclk_out;
    end
  end

  assign sleep_state_o = state == wakeup_clk_pkg::st_sleep;
  assign osc_run_o = !sleep_state_o;
  assign osc_stable_o = stable;
  assign sample_on_rise_o = latch.sample_on_rise;
  assign host_clock_out_o = hclk_out;
  assign baud_clk_o = baud;
  assign data_out_o = dout;
endmodule : wakeup_clk

/* File: src/wakeup_clk_params.svh */
// Purpose: Constants of the wake-up and baud clocking block.
// Assumes: A 200 MHz system clock.
// Notes: Times are in nanoseconds; the settle count is derived from them, the sleep count is given in cycles.
`ifndef WAKEUP_CLK_PARAMS_SVH
`define WAKEUP_CLK_PARAMS_SVH
`define CLK_PERIOD_NS 5
`define XTAL_SETTLE_NS 1500000
`define XTAL_SETTLE_CYCLES (`XTAL_SETTLE_NS / `CLK_PERIOD_NS)
`define SLEEP_TIMEOUT_CYCLES 65536
`define MODE_ASYNC 2'h0
`define MODE_SYNC 2'h1
`define MODE_MANCH 2'h2
`define HOST_CLK_OFF 2'h0
`define HOST_CLK_ALWAYS 2'h1
`define HOST_CLK_TX 2'h2
`define TX_FIFO_DEPTH 4
`endif

/* File: src/wakeup_clk_pkg.sv */
// Purpose: Types shared by the wake-up and baud clocking block.
// Assumes: Nothing beyond the parameter header.
// Notes: Carried records are packed structs.
package wakeup_clk_pkg;
  typedef enum logic [1:0] {
    st_sleep = 2'h0,
    st_settle = 2'h1,
    st_ready = 2'h3
  } wake_state_type;

  typedef struct packed {
    logic sample_on_rise;
    logic host_clk_on;
  } wake_latch_type;
endpackage : wakeup_clk_pkg

/* File: src/wakeup_clk_fifo.sv */
// Purpose: Small FIFO for transmit data bits.
// Assumes: One clock, active-low asynchronous reset.
// Notes: Depth must be a power of two.
`timescale 1ns/10ps
module wakeup_clk_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  assign out_valid_o = wr_ptr != rd_ptr;
  assign in_ready_o = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : wakeup_clk_fifo

/* File: test/wakeup_clk_assertions.sv */
// Purpose: Port checks of the wake-up and baud clocking block.
// Assumes: Reduced settle and sleep counts.
// Notes: Bound to the block below.
`timescale 1ns/10ps
module wakeup_clk_assertions #(
  parameter int SETTLE_CYCLES = 20,
  parameter int SLEEP_CYCLES = 32,
  parameter int DIV_WIDTH = 8
) (
  input logic clk_i,
  input logic rstn_i,
  input logic port_enable_i,
  input logic port_clk_i,
  input logic [DIV_WIDTH-1:0] baud_div_i,
  input logic clk_cfg_load_i,
  input logic tx_start_i,
  input logic tx_ready_o,
  input logic sleep_state_o,
  input logic osc_run_o,
  input logic osc_stable_o,
  input logic sample_on_rise_o,
  input logic host_clock_out_o,
  input logic baud_clk_o
);
  // ----
  // Helpers
  // ----
  localparam int SETTLE_MAX = SETTLE_CYCLES + 4;
  int unsigned low_cnt;
  int unsigned run;
  logic armed;
  logic prev_baud;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // A level cut short by a realign is not measured; lengths count from the second edge on.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt <= 0;
      run <= 0;
      armed <= 1'b0;
      prev_baud <= 1'b0;
    end else begin
      low_cnt <= port_enable_i ? 0 : low_cnt + 1;
      prev_baud <= baud_clk_o;
      if (!osc_stable_o || clk_cfg_load_i || tx_start_i) begin
        run <= 0;
        armed <= 1'b0;
      end else if (baud_clk_o != prev_baud) begin
        run <= armed ? 1 : 0;
        armed <= 1'b1;
      end else if (run != 0) begin
        run <= run + 1;
      end
    end
  end
  property p_tx_gate; !osc_stable_o |-> !tx_ready_o; endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("tx ready early");
  property p_wake; $fell(sleep_state_o) |-> osc_run_o && !osc_stable_o && sample_on_rise_o == port_clk_i; endproperty
  a_wake: assert property (p_wake)
    else $error("wake outputs wrong");
  property p_settle; $rose(osc_run_o) |-> !osc_stable_o [*8] ##[1:SETTLE_MAX] osc_stable_o; endproperty
  a_settle: assert property (p_settle)
    else $error("settle time wrong");
  property p_edge_hold; !sleep_state_o && !$past(sleep_state_o) |-> $stable(sample_on_rise_o); endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("sample edge changed");
  property p_sleep_late; $rose(sleep_state_o) |-> low_cnt >= SLEEP_CYCLES; endproperty
  a_sleep_late: assert property (p_sleep_late)
    else $error("sleep too early");
  property p_sleep_due; low_cnt > SLEEP_CYCLES + 8 |-> sleep_state_o && !osc_run_o; endproperty
  a_sleep_due: assert property (p_sleep_due)
    else $error("sleep missing");
  property p_baud; osc_stable_o && baud_clk_o != prev_baud && run != 0 |-> run == baud_div_i + 1; endproperty
  a_baud: assert property (p_baud)
    else $error("baud level length wrong");
  property p_realign; clk_cfg_load_i || tx_start_i |=> !baud_clk_o && !host_clock_out_o; endproperty
  a_realign: assert property (p_realign)
    else $error("no realign");
endmodule : wakeup_clk_assertions
bind wakeup_clk wakeup_clk_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES), .SLEEP_CYCLES(SLEEP_CYCLES),
  .DIV_WIDTH(DIV_WIDTH)) u_chk (.clk_i, .rstn_i, .port_enable_i, .port_clk_i, .baud_div_i, .clk_cfg_load_i,
  .tx_start_i, .tx_ready_o, .sleep_state_o, .osc_run_o, .osc_stable_o, .sample_on_rise_o, .host_clock_out_o,
  .baud_clk_o);

/* File: test/host_mcu_model.sv */
// Purpose: Microcontroller side of the serial control port.
// Assumes: Called from the bench 1 ns after a rising edge.
// Notes: The serial clock only holds a level; no frames are sent.
`timescale 1ns/10ps
module host_mcu_model (
  input logic clk_i,
  output logic port_enable_o,
  output logic port_clk_o,
  output logic data_o
);
  initial begin
    port_enable_o = 1'b0;
    port_clk_o = 1'b0;
    data_o = 1'b0;
  end
  // Levels are held well past the enable edge so the pin synchronisers see them settled.
  task automatic wake(input logic c, input logic d);
    port_clk_o = c;
    data_o = d;
    repeat (4) @(posedge clk_i);
    #1 port_enable_o = 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
  endtask : wake
  task automatic end_cmd(input int n);
    port_enable_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 port_enable_o = 1'b1;
  endtask : end_cmd
  task automatic drop();
    port_enable_o = 1'b0;
  endtask : drop
  task automatic set_data(input logic d);
    data_o = d;
  endtask : set_data
endmodule : host_mcu_model

/* File: test/wakeup_clk_bench.sv */
// Purpose: Self-checking bench of the wake-up and baud clocking block.
// Assumes: Settle 20 and sleep 32 cycles, baud divider 3.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module wakeup_clk_bench;
  logic clk_i = 1'b0, rstn_i = 1'b0, clk_cfg_load_i = 1'b0, tx_start_i = 1'b0;
  logic tx_active_i = 1'b0, tx_valid_i = 1'b0, tx_bit_i = 1'b0, seen;
  logic [1:0] host_clk_mode_i = 2'h0, data_mode_i = 2'h0;
  logic [7:0] baud_div_i = 8'h03;
  logic port_enable_i, port_clk_i, serial_data_line_i, tx_ready_o, sleep_state_o, osc_run_o, osc_stable_o;
  logic sample_on_rise_o, host_clock_out_o, baud_clk_o, data_out_o;
  int fails = 0, check_count = 0, cycles = 0;
  always #2.5 clk_i = ~clk_i;
  host_mcu_model u_host (.clk_i, .port_enable_o(port_enable_i), .port_clk_o(port_clk_i), .data_o(serial_data_line_i));
  wakeup_clk #(.SETTLE_CYCLES(20), .SLEEP_CYCLES(32)) u_dut (.clk_i, .rstn_i, .port_enable_i, .port_clk_i,
    .serial_data_line_i, .host_clk_mode_i, .data_mode_i, .baud_div_i, .clk_cfg_load_i, .tx_start_i, .tx_active_i,
    .tx_valid_i, .tx_ready_o, .tx_bit_i, .sleep_state_o, .osc_run_o, .osc_stable_o, .sample_on_rise_o,
    .host_clock_out_o, .baud_clk_o, .data_out_o);
  // ----
  // Tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic cmp(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: output mismatch", $time);
    end
  endtask : cmp
  task automatic watch_host(input int n);
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      seen = seen | host_clock_out_o;
    end
  endtask : watch_host
  // Bounded, so a stuck baud clock ends in a mismatch rather than a hang.
  task automatic wait_edge(input logic v);
    for (int k = 0; k < 20 && baud_clk_o !== !v; k++) tick(1);
    for (int k = 0; k < 20 && baud_clk_o !== v; k++) tick(1);
  endtask : wait_edge
  task automatic report_and_stop();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic test_wake();
    host_clk_mode_i = 2'h1;
    clk_cfg_load_i = 1'b1;
    tick(1);
    clk_cfg_load_i = 1'b0;
    u_host.wake(1'b0, 1'b1);
    cmp(osc_run_o, 1'b1);
    cmp(tx_ready_o, 1'b0);
    cmp(sample_on_rise_o, 1'b0);
    tick(18);
    cmp(osc_stable_o, 1'b1);
    watch_host(20);
    cmp(seen, 1'b1);
    $display("wake test done");
  endtask : test_wake
  task automatic test_paths();
    int n;
    n = 0;
    for (int i = 0; i < 6; i++) begin
      tx_valid_i = 1'b1;
      tx_bit_i = i[0] ^ i[1];
      if (tx_ready_o === 1'b1) n++;
      tick(1);
    end
    tx_valid_i = 1'b0;
    cmp(n == 4, 1'b1);
    data_mode_i = 2'h1;
    for (int i = 0; i < 4; i++) begin
      wait_edge(1'b1);
      tick(2);
      cmp(data_out_o, i[0] ^ i[1]);
    end
    cmp(tx_ready_o, 1'b1);
    data_mode_i = 2'h2;
    tx_valid_i = 1'b1;
    tx_bit_i = 1'b1;
    tick(1);
    tx_valid_i = 1'b0;
    wait_edge(1'b1);
    tick(1);
    cmp(data_out_o, 1'b0);
    wait_edge(1'b0);
    tick(1);
    cmp(data_out_o, 1'b1);
    data_mode_i = 2'h0;
    u_host.set_data(1'b0);
    tick(6);
    cmp(data_out_o, 1'b0);
    wait_edge(1'b1);
    tx_start_i = 1'b1;
    tick(1);
    tx_start_i = 1'b0;
    cmp(baud_clk_o, 1'b0);
    $display("path test done");
  endtask : test_paths
  task automatic test_sleep();
    u_host.end_cmd(8);
    cmp(sleep_state_o, 1'b0);
    tick(1);
    u_host.drop();
    tick(45);
    cmp(sleep_state_o, 1'b1);
    u_host.wake(1'b1, 1'b0);
    cmp(sample_on_rise_o, 1'b1);
    watch_host(40);
    cmp(seen, 1'b0);
    host_clk_mode_i = 2'h2;
    clk_cfg_load_i = 1'b1;
    tick(1);
    clk_cfg_load_i = 1'b0;
    u_host.drop();
    tick(45);
    cmp(sleep_state_o, 1'b1);
    u_host.wake(1'b1, 1'b1);
    tick(18);
    cmp(osc_stable_o, 1'b1);
    watch_host(20);
    cmp(seen, 1'b0);
    tx_active_i = 1'b1;
    watch_host(20);
    cmp(seen, 1'b1);
    tx_active_i = 1'b0;
    $display("sleep test done");
  endtask : test_sleep
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    tick(8);
    rstn_i = 1'b1;
    test_wake();
    test_paths();
    test_sleep();
    report_and_stop();
  end
endmodule : wakeup_clk_bench
